// ---- tlia_pkg.sv ----
// package: register map, field positions, reset values and timing constants of the arbiter
package tlia_pkg;
    // register word indices (printed offsets are not all multiples of four: byte offset is index * 4)
    localparam logic [7:0] IDX_CENTRAL = 8'he6;
    localparam logic [7:0] IDX_EDGE = 8'hf2;
    localparam logic [7:0] IDX_PEND = 8'hf3;
    localparam logic [7:0] IDX_MASK = 8'hf4;
    localparam logic [7:0] IDX_PRIO = 8'hf5;
    localparam logic [7:0] IDX_VECT = 8'hf6;
    localparam logic [7:0] IDX_NEST = 8'hf7;
    localparam logic [7:0] IDX_MODE = 8'hf8;
    localparam logic [7:0] IDX_STAT = 8'hf9;
    // central control fields
    localparam int CC_TIMER_EN = 7;
    localparam int CC_TOP_PEND = 6;
    localparam int CC_TOP_EN = 5;
    localparam int CC_GIE = 4;
    localparam int CC_ARB_MODE = 3;
    // vector control fields and the nest lock bit
    localparam int VC_TOP_EDGE = 3;
    localparam int VC_TOP_SRC = 2;
    localparam int VC_A0_SRC = 1;
    localparam int NEST_LOCK = 7;
    // reset values
    localparam logic [7:0] RST_CENTRAL = 8'h87;
    localparam logic [7:0] RST_EDGE = 8'h00;
    localparam logic [7:0] RST_PEND = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_PRIO = 8'hff;
    localparam logic [7:0] RST_VECT = 8'h06;
    localparam logic [7:0] RST_NEST = 8'h00;
    localparam logic [2:0] LVL_LOWEST = 3'h7;
    // arbitration timing in cpu clock cycles
    localparam int SAMPLE_CYCLES = 5;
    localparam int RESOLVE_CYCLES = 6;
    localparam int IMC_BASE = 18;
    localparam int IMC_EXTRA = 2;
    localparam int WAKE_CYCLES = 1;
    localparam logic [4:0] TOP_VECTOR = 5'h00;
    typedef enum logic [2:0] {
        TLIA_IDLE = 3'b000,
        TLIA_RESOLVE = 3'b001,
        TLIA_REQ = 3'b011,
        TLIA_CYCLE = 3'b010,
        TLIA_SERVICE = 3'b110
    } tlia_state_t;
endpackage : tlia_pkg

// ---- tlia_arbiter.sv ----
// top level and external interrupt arbiter with apb register slave
// How it works
// - top source pin or watchdog, pin edge selectable, watchdog rising
// - selected top event sets top pending
// - maskable top needs pending, enable, global
// - lock set only; then pending alone requests
// - nothing granted during top service routine
// - top entry and return keep global enable
// - pending set by hardware, software sets/clears
// - request needs mask, pending and global enable
// - 3-bit level, 0 highest, 7 never served
// - sample every 5, resolve in 6 cycles
// - abort if no write, else finish first
// - external latency 26 to 48 cycles
// - unmaskable top latency 22 to 48 cycles
// - machine cycle 18, plus 2, plus 2
// - waiting core adds one wake-up cycle
// - top pending clears on acknowledge, software sets
// - global enable: cleared external entry, set external return, ei/di
// - current level updated by hardware in nested mode
// - rising when one; d7 edge kept zero
// - external pending set on edge, cleared on acknowledge
// - external needs mask, pending and global enable
// - pair level lsb fixed even 0, odd 1
`timescale 1ns/1ns
module tlia_arbiter
    import tlia_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nmi_pin,
    input wire logic wdg_end_count,
    input wire logic [7:0] ext_pin,
    input wire logic irq_sample_clock,
    input wire logic core_write_done,
    input wire logic core_waiting,
    input wire logic stack_in_regfile,
    input wire logic segment_push_enable,
    input wire logic core_ei,
    input wire logic core_di,
    input wire logic core_iret,
    output logic irq_request,
    output logic irq_abort,
    output logic [7:0] irq_vector,
    output logic irq_routine_start,
    output logic timer_enable
);
    logic [7:0] central_ff, edge_ff, pend_ff, mask_ff, prio_ff, vect_ff, nest_ff;
    logic [7:0] nxt_central, nxt_pend, nxt_nest;
    logic [2:0] hold_ff [0:7];
    logic [7:0] depth_ff;
    logic top_prev_ff, clk_prev_ff;
    logic [7:0] ext_prev_ff;
    logic [2:0] samp_ff;
    logic [2:0] res_ff;
    logic [4:0] cyc_ff;
    tlia_state_t state_ff, nxt_state;
    logic win_top_ff;
    logic [2:0] win_ch_ff;
    logic [2:0] win_lvl_ff;
    logic in_top_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, req_ff, abort_ff, start_ff;
    logic [7:0] vec_ff;

    wire [9:0] word_idx = paddr[11:2];
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_central = word_idx == {2'h0, IDX_CENTRAL};
    wire hit_edge = word_idx == {2'h0, IDX_EDGE};
    wire hit_pend = word_idx == {2'h0, IDX_PEND};
    wire hit_mask = word_idx == {2'h0, IDX_MASK};
    wire hit_prio = word_idx == {2'h0, IDX_PRIO};
    wire hit_vect = word_idx == {2'h0, IDX_VECT};
    wire hit_nest = word_idx == {2'h0, IDX_NEST};
    wire hit_stat = word_idx == {2'h0, IDX_STAT};
    wire mapped = hit_central | hit_edge | hit_pend | hit_mask | hit_prio
        | hit_vect | hit_nest | hit_stat;
    wire [7:0] wd = pwdata[7:0];

    // edges are taken on the slow sample clock enable
    wire samp_en = irq_sample_clock && !clk_prev_ff;
    wire top_src = vect_ff[VC_TOP_SRC] ? nmi_pin : wdg_end_count;
    wire top_rise = top_src && !top_prev_ff;
    wire top_fall = !top_src && top_prev_ff;
    wire top_evt = samp_en && (vect_ff[VC_TOP_SRC]
        ? (vect_ff[VC_TOP_EDGE] ? top_rise : top_fall) : top_rise);
    wire [7:0] ext_src;
    assign ext_src = {ext_pin[7:1], vect_ff[VC_A0_SRC] ? ext_pin[0] : wdg_end_count};
    wire [7:0] ext_evt;
    wire [7:0] ext_req;
    wire [2:0] ch_lvl [0:7];
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_ch
            wire e_edge_sel = (g == 7) ? 1'b0 : edge_ff[g];
            assign ext_evt[g] = samp_en && (e_edge_sel
                ? (ext_src[g] && !ext_prev_ff[g]) : (!ext_src[g] && ext_prev_ff[g]));
            assign ext_req[g] = mask_ff[g] && pend_ff[g] && central_ff[CC_GIE];
            assign ch_lvl[g] = {prio_ff[(g/2)*2+1], prio_ff[(g/2)*2], 1'(g % 2)};
        end
    endgenerate

    wire lock = nest_ff[NEST_LOCK];
    wire top_req = central_ff[CC_TOP_PEND] && (lock ||
        (central_ff[CC_TOP_EN] && central_ff[CC_GIE]));

    // priority search: lowest numbered level wins, ties go to the lower channel
    logic best_ok;
    logic [2:0] best_ch, best_lvl;
    always_comb
    begin
        best_ok = 1'b0;
        best_ch = 3'h0;
        best_lvl = LVL_LOWEST;
        for (int i = 0; i < 8; i++)
        begin
            if (ext_req[i] && ch_lvl[i] != LVL_LOWEST && ch_lvl[i] < best_lvl)
            begin
                best_ok = 1'b1;
                best_ch = 3'(i);
                best_lvl = ch_lvl[i];
            end
        end
    end
    wire [2:0] cur_lvl = central_ff[2:0];
    wire grant_ext = best_ok && best_lvl < cur_lvl;
    wire sample_now = samp_ff == 3'(SAMPLE_CYCLES - 1);
    wire [4:0] imc_len = 5'(IMC_BASE - 1)
        + (stack_in_regfile ? 5'(IMC_EXTRA) : 5'h0)
        + (segment_push_enable ? 5'(IMC_EXTRA) : 5'h0);
    wire entering = state_ff == TLIA_REQ;
    wire ack_ext = entering && !win_top_ff;
    wire ack_top = entering && win_top_ff;
    wire ret_top = core_iret && in_top_ff;
    wire ret_ext = core_iret && !in_top_ff && depth_ff != 8'h0;

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            TLIA_IDLE:
                if (sample_now && !in_top_ff && (top_req || grant_ext))
                    nxt_state = TLIA_RESOLVE;
            TLIA_RESOLVE:
                if (res_ff == 3'(RESOLVE_CYCLES - 1))
                    nxt_state = TLIA_REQ;
            TLIA_REQ:
                if (!core_write_done || core_waiting)
                    nxt_state = TLIA_CYCLE;
            TLIA_CYCLE:
                if (cyc_ff == 5'h0)
                    nxt_state = TLIA_IDLE;
            default:
                nxt_state = TLIA_IDLE;
        endcase
    end

    always_comb
    begin
        nxt_central = central_ff;
        if (wr && hit_central)
            nxt_central = wd;
        if (core_ei)
            nxt_central[CC_GIE] = 1'b1;
        if (core_di)
            nxt_central[CC_GIE] = 1'b0;
        if (ret_ext)
        begin
            nxt_central[CC_GIE] = 1'b1;
            if (central_ff[CC_ARB_MODE])
                nxt_central[2:0] = hold_ff[depth_ff[2:0] - 3'h1];
        end
        if (ack_ext)
        begin
            nxt_central[CC_GIE] = 1'b0;
            if (central_ff[CC_ARB_MODE])
                nxt_central[2:0] = win_lvl_ff;
        end
        if (ack_top)
            nxt_central[CC_TOP_PEND] = 1'b0;
        if (top_evt)
            nxt_central[CC_TOP_PEND] = 1'b1;
    end

    always_comb
    begin
        nxt_pend = pend_ff;
        if (wr && hit_pend)
            nxt_pend = wd;
        if (ack_ext)
            nxt_pend[win_ch_ff] = 1'b0;
        nxt_pend = nxt_pend | ext_evt;
        nxt_nest = nest_ff;
        if (wr && hit_nest)
            nxt_nest = {nest_ff[7] | wd[7], nest_ff[6:0]};
        if (ack_ext && central_ff[CC_ARB_MODE] && cur_lvl != LVL_LOWEST)
            nxt_nest[cur_lvl] = 1'b1;
        if (ret_ext && central_ff[CC_ARB_MODE] && hold_ff[depth_ff[2:0] - 3'h1] != LVL_LOWEST)
            nxt_nest[hold_ff[depth_ff[2:0] - 3'h1]] = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            central_ff <= RST_CENTRAL;
            edge_ff <= RST_EDGE;
            pend_ff <= RST_PEND;
            mask_ff <= RST_MASK;
            prio_ff <= RST_PRIO;
            vect_ff <= RST_VECT;
            nest_ff <= RST_NEST;
        end
        else
        begin
            central_ff <= nxt_central;
            pend_ff <= nxt_pend;
            nest_ff <= nxt_nest;
            if (wr && hit_edge)
                edge_ff <= {1'b0, wd[6:0]};
            if (wr && hit_mask)
                mask_ff <= wd;
            if (wr && hit_prio)
                prio_ff <= wd;
            if (wr && hit_vect)
                vect_ff <= wd;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            top_prev_ff <= 1'b0;
            ext_prev_ff <= 8'h00;
            clk_prev_ff <= 1'b0;
        end
        else
        begin
            clk_prev_ff <= irq_sample_clock;
            if (samp_en)
            begin
                top_prev_ff <= top_src;
                ext_prev_ff <= ext_src;
            end
        end
    end

    // nested save stack of interrupted levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            depth_ff <= 8'h0;
            for (int i = 0; i < 8; i++)
                hold_ff[i] <= LVL_LOWEST;
        end
        else if (ack_ext)
        begin
            hold_ff[depth_ff[2:0]] <= cur_lvl;
            depth_ff <= depth_ff + 8'h1;
        end
        else if (ret_ext)
            depth_ff <= depth_ff - 8'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= TLIA_IDLE;
            samp_ff <= 3'h0;
            res_ff <= 3'h0;
            cyc_ff <= 5'h0;
            win_top_ff <= 1'b0;
            win_ch_ff <= 3'h0;
            win_lvl_ff <= LVL_LOWEST;
            in_top_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            samp_ff <= sample_now ? 3'h0 : samp_ff + 3'h1;
            res_ff <= (state_ff == TLIA_RESOLVE) ? res_ff + 3'h1 : 3'h0;
            if (state_ff == TLIA_IDLE && nxt_state == TLIA_RESOLVE)
            begin
                win_top_ff <= top_req;
                win_ch_ff <= best_ch;
                win_lvl_ff <= best_lvl;
            end
            if (entering && nxt_state == TLIA_CYCLE)
                cyc_ff <= imc_len + (core_waiting ? 5'(WAKE_CYCLES) : 5'h0);
            else if (cyc_ff != 5'h0)
                cyc_ff <= cyc_ff - 5'h1;
            if (ack_top)
                in_top_ff <= 1'b1;
            else if (ret_top)
                in_top_ff <= 1'b0;
        end
    end

    // outputs, all registered; apb answers with zero wait states
    wire [7:0] rd_byte = hit_central ? central_ff : hit_edge ? edge_ff : hit_pend ? pend_ff
        : hit_mask ? mask_ff : hit_prio ? prio_ff : hit_vect ? vect_ff : hit_nest ? nest_ff
        : hit_stat ? {in_top_ff, 2'h0, state_ff == TLIA_IDLE, 1'b0, win_lvl_ff} : 8'h00;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            req_ff <= 1'b0;
            abort_ff <= 1'b0;
            start_ff <= 1'b0;
            vec_ff <= 8'h0;
        end
        else
        begin
            pready_ff <= psel && !penable;
            pslverr_ff <= psel && !penable && !mapped;
            prdata_ff <= {24'h0, rd_byte};
            req_ff <= nxt_state == TLIA_REQ || nxt_state == TLIA_CYCLE;
            abort_ff <= entering && !core_write_done;
            start_ff <= state_ff == TLIA_CYCLE && cyc_ff == 5'h0;
            if (ack_top || ack_ext)
                vec_ff <= win_top_ff ? {3'h0, TOP_VECTOR}
                    : {vect_ff[7:4], win_ch_ff, 1'b0};
        end
    end
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq_request = req_ff;
    assign irq_abort = abort_ff;
    assign irq_vector = vec_ff;
    assign irq_routine_start = start_ff;
    assign timer_enable = central_ff[CC_TIMER_EN];
endmodule : tlia_arbiter

// ---- tlia_checker.sv ----
// checker: port-level timing relations of the arbiter
`timescale 1ns/1ns
module tlia_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq_request,
    input wire logic irq_abort,
    input wire logic irq_routine_start,
    input wire logic timer_enable
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    unmapped_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    start_pulse_a: assert property (irq_routine_start |=> !irq_routine_start)
        else $error("routine start longer than one cycle");
    start_after_req_a: assert property (irq_routine_start |-> $past(irq_request))
        else $error("routine start without request");
    cycle_min_a: assert property ($rose(irq_request) |-> irq_request [*8])
        else $error("machine cycle too short");
    req_drop_a: assert property ($fell(irq_request) |-> irq_routine_start || $past(irq_routine_start))
        else $error("request dropped without routine start");
    abort_with_req_a: assert property (irq_abort |-> irq_request)
        else $error("abort without request");
    abort_pulse_a: assert property (irq_abort |=> !irq_abort)
        else $error("abort longer than one cycle");
    timer_cause_a: assert property ($changed(timer_enable) |->
        $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
        else $error("timer enable changed without a write");
endmodule : tlia_checker

// ---- tlia_core_model.sv ----
// partner: cpu core model giving instruction status and ei, di, iret pulses
`timescale 1ns/1ns
module tlia_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_busy,
    input wire logic [1:0] op,
    output logic core_write_done,
    output logic core_ei,
    output logic core_di,
    output logic core_iret
);
    logic [2:0] wr_cnt_ff;
    // a written instruction runs on a few cycles before it can yield
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) wr_cnt_ff <= 3'h0;
        else if (wr_busy) wr_cnt_ff <= 3'h4;
        else if (wr_cnt_ff != 3'h0) wr_cnt_ff <= wr_cnt_ff - 3'h1;
    assign core_write_done = (wr_cnt_ff != 3'h0);
    assign core_ei = (op == 2'h1);
    assign core_di = (op == 2'h2);
    assign core_iret = (op == 2'h3);
endmodule : tlia_core_model

// ---- tb_top.sv ----
// testbench: registers, arbitration, refusals and response timing of the arbiter
`timescale 1ns/1ns
module tb_top;
    import tlia_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, irq_request, irq_abort, irq_routine_start, timer_enable, e, hit;
    logic nmi_pin = 1'b0, isc = 1'b0, stk = 1'b0, seg = 1'b0, wt = 1'b0, wr = 1'b0;
    logic cwd, cei, cdi, cir, abort_seen = 1'b0;
    logic [7:0] ext_pin = 8'h00, irq_vector;
    logic [1:0] op = 2'h0;
    int error_cnt = 0, samples_checked = 0, cyc = 0, t0, dur = 0, len = 0, base = 0;
    // rows: index, write flag, write data, read-back value
    logic [24:0] rows [14] = '{{IDX_CENTRAL, 17'h00087}, {IDX_PEND, 17'h0}, {IDX_NEST, 17'h0},
        {IDX_EDGE, 17'h0}, {IDX_EDGE, 17'h1ff7f}, {IDX_NEST, 17'h18080}, {IDX_NEST, 17'h10080},
        {IDX_PEND, 17'h10505}, {IDX_PEND, 17'h10000}, {8'h00, 17'h15a00},
        {IDX_CENTRAL, 17'h11717}, {IDX_CENTRAL, 17'h19797}, {IDX_MASK, 17'h10404},
        {IDX_PRIO, 17'h10000}};
    logic [39:0] refuse [5] = '{40'h08ff970800, 40'h04ff960400, 40'h04ff870400,
        40'h0000970400, 40'h04ff970401};
    logic [7:0] mc [4] = '{8'h00, 8'hc4, 8'h21, 8'h10};
    always #2 pclk = ~pclk;
    tlia_arbiter tlia_arbiter_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .nmi_pin, .wdg_end_count(1'b0), .ext_pin,
        .irq_sample_clock(isc), .core_write_done(cwd), .core_waiting(wt), .stack_in_regfile(stk),
        .segment_push_enable(seg), .core_ei(cei), .core_di(cdi), .core_iret(cir), .irq_request,
        .irq_abort, .irq_vector, .irq_routine_start, .timer_enable);
    tlia_core_model tlia_core_model_inst (.pclk, .presetn, .wr_busy(wr), .op,
        .core_write_done(cwd), .core_ei(cei), .core_di(cdi), .core_iret(cir));
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        isc <= ~isc;
        if (irq_abort === 1'b1) abort_seen <= 1'b1;
        if (irq_request === 1'b1) dur <= dur + 1;
        else if (dur != 0)
        begin
            len <= dur;
            dur <= 0;
        end
    end
    task automatic tally_and_finish;
        $display("errors %0d, checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        // look between edges so the answer is seen before the edge that takes it
        @(negedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(negedge pclk);
        end
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            check(0, 1);
            tally_and_finish();
        end
        @(posedge pclk);
    endtask : apb
    // a missing answer that the flow needs ends the run instead of cascading
    task automatic watch(input logic on_start, input int lim, input logic must);
        hit = 1'b0;
        for (int k = 0; k < lim && !hit; k++)
        begin
            @(negedge pclk);
            hit = on_start ? irq_routine_start === 1'b1 : irq_request === 1'b1;
        end
        @(posedge pclk);
        if (must && !hit)
        begin
            check(0, 1);
            tally_and_finish();
        end
    endtask : watch
    task automatic pulse(input logic [1:0] c);
        op <= c;
        @(posedge pclk);
        op <= 2'h0;
        @(posedge pclk);
    endtask : pulse
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i])
        begin
            if (rows[i][16]) apb(rows[i][24:17], 1'b1, rows[i][15:8]);
            apb(rows[i][24:17], 1'b0, 8'h00);
            check(q, {24'h0, rows[i][7:0]});
            check(e, rows[i][24:17] == 8'h00);
        end
        ext_pin <= 8'h0c;
        t0 = cyc;
        watch(1'b1, 100, 1'b1);
        check(cyc - t0 >= 26 && cyc - t0 <= 49, 1);
        check(irq_vector, 8'h04);
        check(abort_seen, 1'b1);
        apb(IDX_PEND, 1'b0, 8'h00);
        check(q, 32'h08);
        apb(IDX_CENTRAL, 1'b0, 8'h00);
        check(q, 32'h87);
        pulse(2'h3);
        apb(IDX_CENTRAL, 1'b0, 8'h00);
        check(q, 32'h97);
        foreach (refuse[i])
        begin
            apb(IDX_PEND, 1'b1, 8'h00);
            apb(IDX_MASK, 1'b1, refuse[i][39:32]);
            apb(IDX_PRIO, 1'b1, refuse[i][31:24]);
            apb(IDX_CENTRAL, 1'b1, refuse[i][23:16]);
            apb(IDX_PEND, 1'b1, refuse[i][15:8]);
            watch(1'b0, 40, 1'b0);
            check(hit, refuse[i][0]);
            if (hit)
            begin
                watch(1'b1, 60, 1'b1);
                pulse(2'h3);
            end
        end
        apb(IDX_PRIO, 1'b1, 8'h00);
        foreach (mc[i])
        begin
            {stk, seg, wt, wr} <= mc[i][7:4];
            apb(IDX_PEND, 1'b1, 8'h04);
            if (mc[i][4])
            begin
                watch(1'b1, 30, 1'b0);
                check(hit, 1'b0);
                wr <= 1'b0;
            end
            watch(1'b1, 100, 1'b1);
            repeat (2) @(posedge pclk);
            if (i == 0) base = len;
            if (!mc[i][4]) check(len - base, mc[i][3:0]);
            pulse(2'h3);
        end
        {stk, seg, wt} <= 3'h0;
        apb(IDX_VECT, 1'b1, 8'h0e);
        apb(IDX_CENTRAL, 1'b1, 8'h87);
        nmi_pin <= 1'b1;
        t0 = cyc;
        watch(1'b1, 100, 1'b1);
        check(cyc - t0 >= 22 && cyc - t0 <= 49, 1);
        check(irq_vector, 8'h00);
        apb(IDX_CENTRAL, 1'b0, 8'h00);
        check(q, 32'h87);
        pulse(2'h1);
        apb(IDX_PEND, 1'b1, 8'h04);
        watch(1'b0, 40, 1'b0);
        check(hit, 1'b0);
        pulse(2'h2);
        pulse(2'h3);
        apb(IDX_CENTRAL, 1'b0, 8'h00);
        check(q, 32'h87);
        nmi_pin <= 1'b0;
        pulse(2'h1);
        watch(1'b1, 100, 1'b1);
        check(irq_vector, 8'h04);
        pulse(2'h3);
        // reset in mid-run: lock and levels return to their reset values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check({irq_request, irq_abort, irq_routine_start, pready}, 4'h0);
        check({timer_enable, irq_vector}, 9'h100);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(IDX_NEST, 1'b0, 8'h00);
        check(q, 32'h00);
        apb(IDX_CENTRAL, 1'b0, 8'h00);
        check(q, 32'h87);
        tally_and_finish();
    end
endmodule : tb_top
bind tlia_arbiter tlia_checker tlia_checker_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .prdata, .pready, .pslverr, .irq_request, .irq_abort, .irq_routine_start, .timer_enable);
